/* line_sel_pkg.sv */
package line_sel_pkg;

    // Width of one cascaded down-counter stage.
    localparam int STAGE_BITS = 4;
    // Default number of stages and the line-select width they imply.
    localparam int DEF_STAGES = 2;
    localparam int SEL_BITS = 8;
    // Default width of the contiguous run length.
    localparam int RUN_BITS = 8;

    // Preset and reset values.
    localparam logic [SEL_BITS-1:0] SEL_ZERO = 8'h00;
    localparam logic [RUN_BITS-1:0] RUN_ZERO = 8'h00;
    localparam logic [RUN_BITS-1:0] RUN_ONE = 8'h01;

    // Load reference choices.
    typedef enum logic [1:0] {
        REF_VERTICAL,
        REF_EVEN_FIELD,
        REF_ODD_FIELD
    } load_ref_t;

    // Sync separator outputs seen by the selector.
    typedef struct packed {
        logic comp_sync;
        logic vertical;
        logic field_odd;
        logic back_porch_b;
    } sync_in_t;

    // Idle levels of the separator outputs: sync and back porch rest high.
    localparam sync_in_t SYNC_IDLE = 4'h9;

    // Output gate controls.
    typedef struct packed {
        logic video_gate;
        logic black_gate;
    } gate_out_t;

endpackage

/* video_line_selector.sv */
// Functional notes
// - The sixteenth sync transition after vertical start marks line 14 in either field.
// - The falling edge of the load reference presets the counter and sets the start-count latch.
// - While the latch is set each sync transition decrements the counter and the borrow gates the video.
// - The falling edge of the final borrow clears the latch until the next load.
// - With the vertical reference one line is chosen per field, or per frame if not interlaced.
// - The field index, inverted for the odd field, can replace the vertical pulse as load reference.
// - The counter chain length is a number of four-bit stages matching the line range.
// - In contiguous mode the gate stays on for a set number of adjoining lines.
// - When no line is passed the back porch pulse enables the black-level path.
`timescale 1ns/1ns
module video_line_selector #(
    parameter int STAGES = line_sel_pkg::DEF_STAGES,
    parameter int RUNW = line_sel_pkg::RUN_BITS
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire line_sel_pkg::sync_in_t SYNC_IN,
    input wire logic [line_sel_pkg::SEL_BITS-1:0] LINE_SELECT_BITS,
    input wire line_sel_pkg::load_ref_t LOAD_REF,
    input wire logic [RUNW-1:0] RUN_LINES,
    output line_sel_pkg::gate_out_t GATE_OUT,
    output logic COUNTING
);
    import line_sel_pkg::*;

    localparam int CW = STAGES * STAGE_BITS;

    ////////////////////////////////////////////////////////////////////////
    // Input registering and edge detection.

    sync_in_t in_r, in_nxt, prev_r, prev_nxt;

    always_comb begin
        in_nxt = SYNC_IN;
        prev_nxt = in_r;
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            // Idle levels, so that release shows no false sync or porch.
            in_r <= SYNC_IDLE;
            prev_r <= SYNC_IDLE;
        end else begin
            in_r <= in_nxt;
            prev_r <= prev_nxt;
        end
    end

    logic sync_edge, ref_level, ref_prev, load_fall;

    always_comb begin
        sync_edge = in_r.comp_sync ^ prev_r.comp_sync;
        case (LOAD_REF)
            REF_EVEN_FIELD: begin
                ref_level = in_r.field_odd;
                ref_prev = prev_r.field_odd;
            end
            REF_ODD_FIELD: begin
                ref_level = ~in_r.field_odd;
                ref_prev = ~prev_r.field_odd;
            end
            default: begin
                ref_level = in_r.vertical;
                ref_prev = prev_r.vertical;
            end
        endcase
        load_fall = ref_prev & ~ref_level;
    end

    ////////////////////////////////////////////////////////////////////////
    // Down-counter chain, start-count latch and contiguous run counter.

    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [RUNW-1:0] run_r, run_nxt;
    logic start_r, start_nxt;
    logic borrow_r, borrow_nxt;

    function automatic logic [CW-1:0] preset(input logic [SEL_BITS-1:0] s);
        logic [CW-1:0] v;
        v = '0;
        for (int i = 0; i < CW && i < SEL_BITS; i++) begin
            v[i] = s[i];
        end
        return v;
    endfunction

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        start_nxt = start_r;
        borrow_nxt = borrow_r;
        if (load_fall) begin
            cnt_nxt = preset(LINE_SELECT_BITS);
            run_nxt = (RUN_LINES == RUN_ZERO) ? RUNW'(RUN_ONE) : RUN_LINES;
            start_nxt = 1'b1;
            borrow_nxt = 1'b0;
        end else if (start_r && sync_edge) begin
            if (borrow_r) begin
                // Two transitions per line; count lines on each pair end.
                if (cnt_r == '0) begin
                    run_nxt = RUNW'(run_r - RUN_ONE);
                    cnt_nxt = {{(CW-1){1'b0}}, 1'b1};
                    if (run_r == RUN_ONE) begin
                        borrow_nxt = 1'b0;
                        start_nxt = 1'b0;
                    end
                end else begin
                    cnt_nxt = CW'(cnt_r - 1'b1);
                end
            end else if (cnt_r == '0) begin
                borrow_nxt = 1'b1;
                cnt_nxt = {{(CW-1){1'b0}}, 1'b1};
            end else begin
                cnt_nxt = CW'(cnt_r - 1'b1);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            cnt_r <= '0;
            run_r <= RUNW'(RUN_ZERO);
            start_r <= 1'b0;
            borrow_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            start_r <= start_nxt;
            borrow_r <= borrow_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output gates.

    gate_out_t gate_r, gate_nxt;

    // The black path opens only while no line is gated, so they never overlap.

    always_comb begin
        gate_nxt.video_gate = borrow_nxt;
        gate_nxt.black_gate = ~borrow_nxt & ~in_r.back_porch_b;
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            gate_r <= '0;
        end else begin
            gate_r <= gate_nxt;
        end
    end

    assign GATE_OUT = gate_r;
    assign COUNTING = start_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    a_load_sets_latch: assert property (@(posedge CLK) disable iff (!RST_B)
        load_fall |=> start_r)
        else $error("load did not set start latch");

    a_borrow_ends_latch: assert property (@(posedge CLK) disable iff (!RST_B)
        ($fell(borrow_r) && !$past(load_fall)) |-> !start_r)
        else $error("borrow end left latch set");

    a_gate_follows_borrow: assert property (@(posedge CLK)
        disable iff (!RST_B)
        gate_r.video_gate == $past(borrow_nxt))
        else $error("video gate not tracking borrow");

    a_no_count_idle: assert property (@(posedge CLK) disable iff (!RST_B)
        (!start_r && !load_fall) |=> $stable(cnt_r))
        else $error("counter moved while idle");

    a_count_on_edge: assert property (@(posedge CLK) disable iff (!RST_B)
        (start_r && !sync_edge && !load_fall) |=> $stable(cnt_r))
        else $error("counter moved without sync edge");

    a_black_exclusive: assert property (@(posedge CLK) disable iff (!RST_B)
        !(gate_r.video_gate && gate_r.black_gate))
        else $error("black and video gates both on");

    a_edge_detect: assert property (@(posedge CLK) disable iff (!RST_B)
        sync_edge |-> (in_r.comp_sync != $past(in_r.comp_sync)))
        else $error("sync edge without input change");

    a_borrow_needs_latch: assert property (@(posedge CLK)
        disable iff (!RST_B)
        $rose(borrow_r) |-> $past(start_r))
        else $error("borrow without counting");

    a_gate_needs_latch: assert property (@(posedge CLK) disable iff (!RST_B)
        gate_r.video_gate |-> start_r)
        else $error("video gate open with latch clear");

    a_black_on_porch: assert property (@(posedge CLK) disable iff (!RST_B)
        (!borrow_nxt && !in_r.back_porch_b) |=> gate_r.black_gate)
        else $error("black gate missing in back porch");

    a_run_nonzero: assert property (@(posedge CLK) disable iff (!RST_B)
        load_fall |=> (run_r != '0))
        else $error("run length zero after load");

    a_cnt_preset: assert property (@(posedge CLK) disable iff (!RST_B)
        load_fall |=> (cnt_r == preset($past(LINE_SELECT_BITS))))
        else $error("counter not preset from line select");

    // Main scenarios.
    c_line_gated: cover property (@(posedge CLK) disable iff (!RST_B)
        $rose(gate_r.video_gate));
    c_run_done: cover property (@(posedge CLK) disable iff (!RST_B)
        $fell(start_r));
    c_odd_ref: cover property (@(posedge CLK) disable iff (!RST_B)
        load_fall && LOAD_REF == REF_ODD_FIELD);
    c_even_ref: cover property (@(posedge CLK) disable iff (!RST_B)
        load_fall && LOAD_REF == REF_EVEN_FIELD);
    c_multi_line: cover property (@(posedge CLK) disable iff (!RST_B)
        borrow_r && sync_edge && run_r != RUNW'(RUN_ONE));

endmodule // video_line_selector

/* sync_source_model.sv */
`timescale 1ns/1ns
module sync_source_model #(
    parameter int SP = 8
) (
    input wire logic CLK,
    output line_sel_pkg::sync_in_t SYNC,
    output int TRANS
);
    import line_sel_pkg::*;
    initial begin
        SYNC = SYNC_IDLE;
        TRANS = 0;
    end
    // Sends one field: a vertical pulse, then n sync transitions.
    task automatic send_field(input logic odd, input int n);
        @(negedge CLK);
        SYNC.vertical <= 1'b1;
        SYNC.comp_sync <= ~SYNC.comp_sync;
        repeat (SP) @(negedge CLK);
        SYNC.vertical <= 1'b0;
        SYNC.field_odd <= odd;
        TRANS <= 0;
        repeat (n) begin
            repeat (SP - 2) @(negedge CLK);
            SYNC.back_porch_b <= SYNC.comp_sync;
            SYNC.comp_sync <= ~SYNC.comp_sync;
            TRANS <= TRANS + 1;
            repeat (2) @(negedge CLK);
            SYNC.back_porch_b <= 1'b1;
        end
    endtask
endmodule // sync_source_model

/* tb_video_line_selector.sv */
`timescale 1ns/1ns
module tb_video_line_selector;
    import line_sel_pkg::*;
    localparam int SP = 8;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    sync_in_t sync;
    logic [SEL_BITS-1:0] sel = SEL_ZERO;
    load_ref_t lref = REF_VERTICAL;
    logic [RUN_BITS-1:0] run = RUN_ONE;
    gate_out_t gate;
    logic counting;
    int trans, failures = 0, n_checks = 0, cyc = 0;
    int gate_cyc, first_idx, both_cyc, black_cyc;
    always #2 clk = ~clk;
    sync_source_model #(.SP(SP)) src (.CLK(clk), .SYNC(sync), .TRANS(trans));
    video_line_selector dut (.CLK(clk), .RST_B(rst_b), .SYNC_IN(sync),
        .LINE_SELECT_BITS(sel), .LOAD_REF(lref), .RUN_LINES(run),
        .GATE_OUT(gate), .COUNTING(counting));
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (gate.video_gate === 1'b1) begin
            if (gate_cyc == 0) first_idx = trans;
            gate_cyc = gate_cyc + 1;
        end
        if (gate.black_gate === 1'b1) black_cyc = black_cyc + 1;
        if (gate === 2'h3) both_cyc = both_cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            end_of_test();
        end
    end
    task automatic check_count(input int got, input int exp, string what);
        n_checks = n_checks + 1;
        if (got != exp) begin
            failures = failures + 1;
            $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, string what);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic run_field(input int p, input int r, input logic odd);
        @(negedge clk);
        sel = p[SEL_BITS-1:0];
        run = r[RUN_BITS-1:0];
        gate_cyc = 0;
        both_cyc = 0;
        black_cyc = 0;
        src.send_field(odd, p + 2 * r + 8);
    endtask
    task automatic judge(input int p, input int r, input bit on);
        int er;
        er = (r == 0) ? 1 : r;
        check_count(gate_cyc, on ? 2 * er * SP : 0, "gate length");
        if (on) check_count(first_idx, p + 1, "gate start");
        check_bit(counting, 1'b0, "latch still set");
        check_count(both_cyc, 0, "black with video");
        check_bit(black_cyc > 0, 1'b1, "no black gate");
    endtask
    task automatic t_single_line();
        run_field(16, 1, 1'b0);
        judge(16, 1, 1'b1);
        run_field(2, 1, 1'b1);
        judge(2, 1, 1'b1);
        $display("single line test done");
    endtask
    task automatic t_contiguous();
        run_field(5, 3, 1'b0);
        judge(5, 3, 1'b1);
        run_field(9, 0, 1'b1);
        judge(9, 0, 1'b1);
        $display("contiguous test done");
    endtask
    task automatic t_field_select();
        lref = REF_EVEN_FIELD;
        run_field(4, 1, 1'b1);
        judge(4, 1, 1'b0);
        run_field(4, 1, 1'b0);
        judge(4, 1, 1'b1);
        lref = REF_ODD_FIELD;
        run_field(4, 1, 1'b0);
        judge(4, 1, 1'b0);
        run_field(4, 1, 1'b1);
        judge(4, 1, 1'b1);
        $display("field select test done");
    endtask
    task automatic t_reset();
        repeat (2) begin
            @(negedge clk);
            check_bit(gate.black_gate, 1'b0, "black after reset");
            check_bit(counting, 1'b0, "latch after reset");
        end
        sel = 8'h03;
        run = 8'h04;
        fork
            src.send_field(1'b0, 24);
            begin
                wait (gate.video_gate === 1'b1);
                @(negedge clk);
                rst_b = 1'b0;
                repeat (2) @(negedge clk);
                rst_b = 1'b1;
                @(negedge clk);
                check_bit(gate.video_gate, 1'b0, "gate mid reset");
                check_bit(counting, 1'b0, "latch mid reset");
            end
        join
        check_bit(counting, 1'b0, "counted without load");
        check_bit(gate.video_gate, 1'b0, "gate without load");
        $display("reset test done");
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_single_line();
        t_contiguous();
        t_field_select();
        end_of_test();
    end
endmodule // tb_video_line_selector
